/* File: logic/fdh_defs.svh */
// Purpose: constants of the flash-store command handler
// Assumes: one 20 MHz clock, byte streams on both sides
// Notes: header layout is big-endian, eight bytes before payload
`ifndef FDH_DEFS_SVH
`define FDH_DEFS_SVH

`define FDH_CMD_ERASE 8'h01
`define FDH_CMD_STORE 8'h02
`define FDH_CMD_CLEAR_STORE 8'h03
`define FDH_CMD_READ 8'h04
`define FDH_REPLY_FLAG 8'h80
`define FDH_STATUS_RSVD 7'h00
`define FDH_LAST_BLOCK 16'h009f
`define FDH_BLOCK_BYTES 17'h00200
`define FDH_HDR_LAST 4'h7
`define FDH_FIFO_DEPTH 16

`endif

/* File: logic/fdh_pkg.sv */
// Purpose: types shared by the flash-store command handler
// Assumes: fdh_defs.svh holds every number
// Notes: header struct packs byte 0 into the top bits
package fdh_pkg;

`include "fdh_defs.svh"

	typedef struct packed
	{
		logic [7:0] cmd;
		logic [7:0] opt;
		logic [15:0] block;
		logic [15:0] start;
		logic [15:0] count;
	} fdh_req_type;

	typedef struct packed
	{
		logic last;
		logic [7:0] data;
	} fdh_byte_type;

	typedef enum logic [2:0]
	{
		FDH_OP_NONE = 3'h0,
		FDH_OP_ERASE_BLOCK = 3'h1,
		FDH_OP_ERASE_ALL = 3'h2,
		FDH_OP_WRITE = 3'h3,
		FDH_OP_READ = 3'h4
	} fdh_op_type;

	typedef struct packed
	{
		fdh_op_type op;
		logic [7:0] block;
		logic [8:0] offset;
		logic [7:0] wdata;
	} fdh_flash_cmd_type;

	typedef enum logic [8:0]
	{
		FDH_ST_HDR = 9'h001,
		FDH_ST_CHECK = 9'h002,
		FDH_ST_ERASE = 9'h004,
		FDH_ST_WDATA = 9'h008,
		FDH_ST_WWAIT = 9'h010,
		FDH_ST_DRAIN = 9'h020,
		FDH_ST_REPLY = 9'h040,
		FDH_ST_RWAIT = 9'h080,
		FDH_ST_RPUSH = 9'h100
	} fdh_state_type;

endpackage

/* File: logic/fdh_handler.sv */
// Purpose: flash-store command handler: erase, store, clear-then-store, read
// Assumes: request and reply streams and flash port run on clk_i
// Notes: replies leave through a 16-word FIFO; tx back-pressure stalls the handler
//
// How it works
// - erase reply carries code 0x81 to requester
// - outcome bit zero set on failure only
// - erase reply echoes block and start index
// - erase reply count zero, no payload
// - codes 0x02 store, 0x03 clear-then-store
// - clear-then-store erases whole block first
// - store block index 0..159, one block
// - payload written from start index onward
// - byte count zero erases whole store
// - store replies 0x82, clear-then-store 0x83
// - store replies echo indices, count zero
// - read code 0x04 fetches requested bytes
// - store replies only for unicast, to source
// - big-endian header, payload from offset 8
// - broadcast requests get no reply
// - read reply 0x84 carries bytes read
`timescale 1ns/10ps
`include "fdh_defs.svh"

module fdh_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// fill side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// drain side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [AW:0] count_reg, count_next;
	logic out_valid_reg, out_valid_next;
	logic [WIDTH-1:0] out_data_reg, out_data_next;
	logic push, load;

	always_comb
	begin
		in_ready_o = (count_reg != FULL);
		push = in_valid_i && in_ready_o;
		// output stage refills as soon as it empties or is taken
		load = (count_reg != '0) && (!out_valid_reg || out_ready_i);
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		count_next = count_reg;
		out_valid_next = out_valid_reg;
		out_data_next = out_data_reg;
		if (push)
		begin
			wr_ptr_next = wr_ptr_reg + 1'b1;
		end
		if (load)
		begin
			rd_ptr_next = rd_ptr_reg + 1'b1;
			out_valid_next = 1'b1;
			out_data_next = mem[rd_ptr_reg];
		end
		else if (out_ready_i)
		begin
			out_valid_next = 1'b0;
		end
		if (push && !load)
		begin
			count_next = count_reg + 1'b1;
		end
		else if (load && !push)
		begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (push)
		begin
			mem[wr_ptr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			out_valid_reg <= 1'b0;
			out_data_reg <= '0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg <= count_next;
			out_valid_reg <= out_valid_next;
			out_data_reg <= out_data_next;
		end
	end

	assign out_valid_o = out_valid_reg;
	assign out_data_o = out_data_reg;
endmodule

module fdh_handler (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// request byte stream
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_last_i,
	input wire logic rx_unicast_i,
	output logic rx_ready_o,
	// reply byte stream
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic tx_last_o,
	input wire logic tx_ready_i,
	// flash store port
	output logic flash_req_o,
	output fdh_pkg::fdh_flash_cmd_type flash_cmd_o,
	input wire logic flash_done_i,
	input wire logic flash_fail_i,
	input wire logic [7:0] flash_rdata_i,
	// status
	output logic busy_o
);
	import fdh_pkg::*;

	fdh_state_type state_reg, state_next;
	fdh_req_type hdr_reg, hdr_next;
	logic [3:0] hdr_cnt_reg, hdr_cnt_next;
	logic [3:0] idx_reg, idx_next;
	logic unicast_reg, unicast_next;
	logic frame_done_reg, frame_done_next;
	logic fail_reg, fail_next;
	logic [15:0] remain_reg, remain_next;
	logic [15:0] offset_reg, offset_next;
	logic [7:0] rdata_reg, rdata_next;
	logic flash_req_reg, flash_req_next;
	fdh_flash_cmd_type flash_cmd_reg, flash_cmd_next;
	logic rx_ready_reg, rx_ready_next;
	logic busy_reg, busy_next;

	logic take, push_valid, push_ready, known, bad_block, bad_span, is_read, is_store;
	logic read_data;
	logic [15:0] reply_count;
	fdh_state_type finish_state;
	fdh_byte_type push_byte, out_byte;

	function automatic logic [7:0] reply_byte(input fdh_req_type h, input logic f,
		input logic [3:0] i, input logic [15:0] cnt);
		case (i)
			4'h0: reply_byte = h.cmd | `FDH_REPLY_FLAG;
			4'h1: reply_byte = {`FDH_STATUS_RSVD, f};
			4'h2: reply_byte = h.block[15:8];
			4'h3: reply_byte = h.block[7:0];
			4'h4: reply_byte = h.start[15:8];
			4'h5: reply_byte = h.start[7:0];
			4'h6: reply_byte = cnt[15:8];
			default: reply_byte = cnt[7:0];
		endcase
	endfunction

	always_comb
	begin
		take = rx_valid_i && rx_ready_reg;
		is_read = (hdr_reg.cmd == `FDH_CMD_READ);
		is_store = (hdr_reg.cmd == `FDH_CMD_STORE) || (hdr_reg.cmd == `FDH_CMD_CLEAR_STORE);
		known = is_read || is_store || (hdr_reg.cmd == `FDH_CMD_ERASE);
		bad_block = (hdr_reg.block > `FDH_LAST_BLOCK);
		bad_span = ({1'b0, hdr_reg.start} + {1'b0, hdr_reg.count}) > `FDH_BLOCK_BYTES;
		read_data = is_read && !fail_reg && (hdr_reg.count != 16'h0000);
		// only a good read carries data; all other replies keep count zero
		reply_count = (is_read && !fail_reg) ? hdr_reg.count : 16'h0000;
		// no reply for broadcast or unknown commands
		finish_state = !frame_done_reg ? FDH_ST_DRAIN :
			(unicast_reg ? FDH_ST_REPLY : FDH_ST_HDR);
		push_valid = 1'b0;
		push_byte = '0;
		state_next = state_reg;
		hdr_next = hdr_reg;
		hdr_cnt_next = hdr_cnt_reg;
		idx_next = idx_reg;
		unicast_next = unicast_reg;
		frame_done_next = frame_done_reg;
		fail_next = fail_reg;
		remain_next = remain_reg;
		offset_next = offset_reg;
		rdata_next = rdata_reg;
		flash_req_next = flash_req_reg;
		flash_cmd_next = flash_cmd_reg;
		flash_cmd_next.block = hdr_reg.block[7:0];
		case (state_reg)
			FDH_ST_HDR:
			begin
				if (take)
				begin
					hdr_next = fdh_req_type'({hdr_reg[55:0], rx_data_i});
					if (hdr_cnt_reg == 4'h0)
					begin
						unicast_next = rx_unicast_i;
					end
					fail_next = 1'b0;
					frame_done_next = rx_last_i;
					if (hdr_cnt_reg == `FDH_HDR_LAST)
					begin
						hdr_cnt_next = 4'h0;
						state_next = FDH_ST_CHECK;
					end
					else if (rx_last_i)
					begin
						// runt frame: dropped silently
						hdr_cnt_next = 4'h0;
					end
					else
					begin
						hdr_cnt_next = hdr_cnt_reg + 4'h1;
					end
				end
			end
			FDH_ST_CHECK:
			begin
				remain_next = hdr_reg.count;
				offset_next = hdr_reg.start;
				idx_next = 4'h0;
				flash_cmd_next.offset = 9'h000;
				if (!known)
				begin
					unicast_next = 1'b0;
					state_next = frame_done_reg ? FDH_ST_HDR : FDH_ST_DRAIN;
				end
				else if (!is_read && hdr_reg.count == 16'h0000)
				begin
					flash_req_next = 1'b1;
					flash_cmd_next.op = FDH_OP_ERASE_ALL;
					state_next = FDH_ST_ERASE;
				end
				else if (bad_block || (!(hdr_reg.cmd == `FDH_CMD_ERASE) && bad_span))
				begin
					fail_next = 1'b1;
					state_next = finish_state;
				end
				else if (is_read)
				begin
					state_next = finish_state;
				end
				else if (hdr_reg.cmd == `FDH_CMD_STORE)
				begin
					state_next = FDH_ST_WDATA;
				end
				else
				begin
					flash_req_next = 1'b1;
					flash_cmd_next.op = FDH_OP_ERASE_BLOCK;
					state_next = FDH_ST_ERASE;
				end
			end
			FDH_ST_ERASE:
			begin
				if (flash_done_i)
				begin
					flash_req_next = 1'b0;
					fail_next = fail_reg | flash_fail_i;
					// zero count or plain erase ends here; store waits for erase
					if (is_store && remain_reg != 16'h0000 && !flash_fail_i)
					begin
						state_next = FDH_ST_WDATA;
					end
					else
					begin
						state_next = finish_state;
					end
				end
			end
			FDH_ST_WDATA:
			begin
				if (frame_done_reg)
				begin
					// payload shorter than the byte count
					fail_next = 1'b1;
					state_next = finish_state;
				end
				else if (take)
				begin
					flash_req_next = 1'b1;
					flash_cmd_next.op = FDH_OP_WRITE;
					flash_cmd_next.offset = offset_reg[8:0];
					flash_cmd_next.wdata = rx_data_i;
					offset_next = offset_reg + 16'h0001;
					remain_next = remain_reg - 16'h0001;
					frame_done_next = rx_last_i;
					state_next = FDH_ST_WWAIT;
				end
			end
			FDH_ST_WWAIT:
			begin
				if (flash_done_i)
				begin
					flash_req_next = 1'b0;
					fail_next = fail_reg | flash_fail_i;
					state_next = (remain_reg == 16'h0000) ? finish_state : FDH_ST_WDATA;
				end
			end
			FDH_ST_DRAIN:
			begin
				if (take && rx_last_i)
				begin
					frame_done_next = 1'b1;
					state_next = unicast_reg ? FDH_ST_REPLY : FDH_ST_HDR;
				end
			end
			FDH_ST_REPLY:
			begin
				push_valid = 1'b1;
				push_byte.data = reply_byte(hdr_reg, fail_reg, idx_reg, reply_count);
				push_byte.last = (idx_reg == `FDH_HDR_LAST) && !read_data;
				if (push_ready)
				begin
					idx_next = idx_reg + 4'h1;
					if (idx_reg == `FDH_HDR_LAST)
					begin
						if (read_data)
						begin
							flash_req_next = 1'b1;
							flash_cmd_next.op = FDH_OP_READ;
							flash_cmd_next.offset = offset_reg[8:0];
							state_next = FDH_ST_RWAIT;
						end
						else
						begin
							state_next = FDH_ST_HDR;
						end
					end
				end
			end
			FDH_ST_RWAIT:
			begin
				if (flash_done_i)
				begin
					flash_req_next = 1'b0;
					rdata_next = flash_rdata_i;
					offset_next = offset_reg + 16'h0001;
					remain_next = remain_reg - 16'h0001;
					state_next = FDH_ST_RPUSH;
				end
			end
			FDH_ST_RPUSH:
			begin
				push_valid = 1'b1;
				push_byte.data = rdata_reg;
				push_byte.last = (remain_reg == 16'h0000);
				if (push_ready)
				begin
					if (remain_reg == 16'h0000)
					begin
						state_next = FDH_ST_HDR;
					end
					else
					begin
						flash_req_next = 1'b1;
						flash_cmd_next.op = FDH_OP_READ;
						flash_cmd_next.offset = offset_reg[8:0];
						state_next = FDH_ST_RWAIT;
					end
				end
			end
			default:
			begin
				state_next = FDH_ST_HDR;
			end
		endcase
		// ready must not outlive the frame, or a new frame's byte is eaten
		rx_ready_next = (state_next == FDH_ST_HDR) || (state_next == FDH_ST_DRAIN) ||
			((state_next == FDH_ST_WDATA) && !frame_done_next);
		busy_next = (state_next != FDH_ST_HDR);
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg <= FDH_ST_HDR;
			hdr_reg <= '0;
			hdr_cnt_reg <= 4'h0;
			idx_reg <= 4'h0;
			unicast_reg <= 1'b0;
			frame_done_reg <= 1'b0;
			fail_reg <= 1'b0;
			remain_reg <= 16'h0000;
			offset_reg <= 16'h0000;
			rdata_reg <= 8'h00;
			flash_req_reg <= 1'b0;
			flash_cmd_reg <= '0;
			rx_ready_reg <= 1'b0;
			busy_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			hdr_reg <= hdr_next;
			hdr_cnt_reg <= hdr_cnt_next;
			idx_reg <= idx_next;
			unicast_reg <= unicast_next;
			frame_done_reg <= frame_done_next;
			fail_reg <= fail_next;
			remain_reg <= remain_next;
			offset_reg <= offset_next;
			rdata_reg <= rdata_next;
			flash_req_reg <= flash_req_next;
			flash_cmd_reg <= flash_cmd_next;
			rx_ready_reg <= rx_ready_next;
			busy_reg <= busy_next;
		end
	end

	fdh_fifo #(
		.WIDTH($bits(fdh_byte_type)),
		.DEPTH(`FDH_FIFO_DEPTH)
	) u_reply_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(push_valid),
		.in_data_i(push_byte),
		.in_ready_o(push_ready),
		.out_valid_o(tx_valid_o),
		.out_data_o(out_byte),
		.out_ready_i(tx_ready_i)
	);

	assign tx_data_o = out_byte.data;
	assign tx_last_o = out_byte.last;
	assign rx_ready_o = rx_ready_reg;
	assign flash_req_o = flash_req_reg;
	assign flash_cmd_o = flash_cmd_reg;
	assign busy_o = busy_reg;
endmodule

/* File: test/fdh_handler_properties.sv */
// Purpose: port-level checks of the flash-store command handler
// Assumes: one clock domain, reset active high
// Notes: reply byte index kept in helper logic
`timescale 1ns/10ps
module fdh_handler_properties
	import fdh_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// request stream
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_last_i,
	input wire logic rx_unicast_i,
	input wire logic rx_ready_o,
	// reply stream
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_last_o,
	input wire logic tx_ready_i,
	// flash port and status
	input wire logic flash_req_o,
	input wire fdh_flash_cmd_type flash_cmd_o,
	input wire logic flash_done_i,
	input wire logic flash_fail_i,
	input wire logic [7:0] flash_rdata_i,
	input wire logic busy_o
);
	logic [4:0] idx_reg, idx_next;
	logic [7:0] code_reg, code_next;
	always_comb
	begin
		idx_next = idx_reg;
		code_next = code_reg;
		if (tx_valid_o && tx_ready_i)
		begin
			// saturates: only the header bytes matter here
			idx_next = tx_last_o ? 5'h00 : idx_reg + {4'h0, idx_reg != 5'h1f};
			if (idx_reg == 5'h00)
				code_next = tx_data_o;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i)
		begin
			idx_reg <= 5'h00;
			code_reg <= 8'h00;
		end
		else
		begin
			idx_reg <= idx_next;
			code_reg <= code_next;
		end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_req_open;
		flash_req_o && !flash_done_i;
	endsequence
	sequence s_req_done;
		flash_req_o && flash_done_i;
	endsequence
	a_req_holds_cmd: assert property (s_req_open |=> flash_req_o && $stable(flash_cmd_o))
		else $error("flash request changed before done");
	a_req_ends_done: assert property (s_req_done |=> !flash_req_o)
		else $error("flash request not dropped after done");
	a_op_legal: assert property (flash_req_o |-> flash_cmd_o.op inside {[3'h1:3'h4]})
		else $error("flash op code out of range");
	a_tx_holds_byte: assert property (tx_valid_o && !tx_ready_i |=>
		tx_valid_o && $stable({tx_data_o, tx_last_o}))
		else $error("reply byte changed while stalled");
	a_rx_stops_last: assert property (rx_valid_i && rx_ready_o && rx_last_i |=> !rx_ready_o)
		else $error("request taken past frame end");
	a_code_is_reply: assert property (tx_valid_o && idx_reg == 5'h00 |->
		tx_data_o inside {8'h81, 8'h82, 8'h83, 8'h84})
		else $error("bad reply code");
	a_outcome_reserved: assert property (tx_valid_o && idx_reg == 5'h01 |->
		tx_data_o[7:1] == 7'h00)
		else $error("reserved outcome bits set");
	a_count_zero: assert property (tx_valid_o && idx_reg inside {5'h06, 5'h07} &&
		code_reg != 8'h84 |-> tx_data_o == 8'h00)
		else $error("nonzero count in reply");
	a_hdr_not_last: assert property (tx_valid_o && idx_reg < 5'h07 |-> !tx_last_o)
		else $error("reply ended inside header");
endmodule
bind fdh_handler fdh_handler_properties i_fdh_handler_properties (.clk_i, .rst_i, .rx_valid_i,
	.rx_data_i, .rx_last_i, .rx_unicast_i, .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_last_o,
	.tx_ready_i, .flash_req_o, .flash_cmd_o, .flash_done_i, .flash_fail_i, .flash_rdata_i,
	.busy_o);

/* File: test/fdh_flash_model.sv */
// Purpose: behavioural flash store behind the handler
// Assumes: 160 blocks of 512 bytes, unwritten bytes read as ones
// Notes: latency alternates between one and four cycles
`timescale 1ns/10ps
module fdh_flash_model
	import fdh_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// flash port
	input wire logic flash_req_i,
	input wire fdh_flash_cmd_type flash_cmd_i,
	output logic flash_done_o,
	output logic flash_fail_o,
	output logic [7:0] flash_rdata_o,
	// test control
	input wire logic fail_next_i,
	output int n_ops_o
);
	logic [7:0] mem [int];
	int cnt, lat, a, b;
	logic wait_low;
	function automatic logic [7:0] peek(input int x);
		return mem.exists(x) ? mem[x] : 8'hff;
	endfunction
	always @(posedge clk_i or posedge rst_i)
	begin
		b = flash_cmd_i.block * 512;
		a = b + flash_cmd_i.offset;
		// data lines wander outside a done pulse
		flash_rdata_o <= ~flash_rdata_o;
		flash_done_o <= 0;
		flash_fail_o <= 0;
		if (rst_i)
		begin
			flash_rdata_o <= 8'h00;
			cnt <= 0;
			lat <= 0;
			wait_low <= 0;
			n_ops_o <= 0;
		end
		else if (flash_done_o)
			wait_low <= 1;
		else if (wait_low)
			wait_low <= flash_req_i;
		else if (flash_req_i && cnt < lat)
			cnt <= cnt + 1;
		else if (flash_req_i)
		begin
			cnt <= 0;
			lat <= 3 - lat;
			flash_done_o <= 1;
			flash_fail_o <= fail_next_i;
			n_ops_o <= n_ops_o + 1;
			if (!fail_next_i)
				case (flash_cmd_i.op)
					FDH_OP_ERASE_BLOCK: for (int i = 0; i < 512; i++) mem.delete(b + i);
					FDH_OP_ERASE_ALL: mem.delete();
					FDH_OP_WRITE: mem[a] = flash_cmd_i.wdata;
					FDH_OP_READ: flash_rdata_o <= peek(a);
					default: ;
				endcase
		end
	end
endmodule

/* File: test/fdh_handler_tb.sv */
// Purpose: request-level tests of the flash-store command handler
// Assumes: inputs change on the falling edge
// Notes: sink stalls every third cycle to exercise the reply FIFO
`timescale 1ns/10ps
module fdh_handler_tb;
	import fdh_pkg::*;
	logic clk_i, rst_i, rx_valid_i, rx_last_i, rx_unicast_i;
	logic tx_ready_i, fail_next, stall = 0;
	logic [7:0] rx_data_i;
	logic rx_ready_o, tx_valid_o, tx_last_o, flash_req_o, flash_done_i, flash_fail_i, busy_o;
	logic [7:0] tx_data_o, flash_rdata_i;
	fdh_flash_cmd_type flash_cmd_o;
	int miscompares = 0, n_compared = 0, n_ops, n0, last_at = 0;
	logic [7:0] p[$], rq[$];
	fdh_handler i_fdh_handler (.clk_i, .rst_i, .rx_valid_i, .rx_data_i, .rx_last_i,
		.rx_unicast_i, .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_last_o, .tx_ready_i,
		.flash_req_o, .flash_cmd_o, .flash_done_i, .flash_fail_i, .flash_rdata_i, .busy_o);
	fdh_flash_model i_fdh_flash_model (.clk_i, .rst_i, .flash_req_i(flash_req_o),
		.flash_cmd_i(flash_cmd_o), .flash_done_o(flash_done_i), .flash_fail_o(flash_fail_i),
		.flash_rdata_o(flash_rdata_i), .fail_next_i(fail_next), .n_ops_o(n_ops));
	initial
	begin
		clk_i = 0;
		forever #25 clk_i = ~clk_i;
	end
	// falling edges fall on multiples of 50 ns, so one in three stalls
	always @(negedge clk_i)
		tx_ready_i <= !stall && ($time % 150 != 0);
	always @(posedge clk_i)
		if (tx_valid_o && tx_ready_i)
		begin
			rq.push_back(tx_data_o);
			if (tx_last_o)
				last_at = rq.size();
		end
	task chk(input logic [15:0] s, e);
		n_compared++;
		if (s !== e)
		begin
			miscompares++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	task send(input logic [7:0] c, input logic [15:0] b, s, n, input logic u);
		logic [7:0] d[$];
		d = {c, 8'h00, b[15:8], b[7:0], s[15:8], s[7:0], n[15:8], n[7:0], p};
		for (int k = 0; k < d.size(); k++)
		begin
			@(negedge clk_i);
			rx_valid_i = 1;
			rx_data_i = d[k];
			rx_last_i = k == d.size() - 1;
			rx_unicast_i = u;
			do @(posedge clk_i); while (rx_ready_o !== 1'b1);
		end
		@(negedge clk_i);
		rx_valid_i = 0;
	endtask
	task rep(input logic [7:0] c, f, input logic [15:0] b, s, n, input int nd);
		repeat (4000)
			if (rq.size() < 8 + nd)
				@(posedge clk_i);
		chk(16'(rq.size()), 16'(8 + nd));
		chk(16'(last_at), 16'(8 + nd));
		chk(16'(busy_o), 16'h0000);
		chk({rq[0], rq[1]}, {c, f});
		chk({rq[2], rq[3]}, b);
		chk({rq[4], rq[5]}, s);
		chk({rq[6], rq[7]}, n);
		for (int i = 0; i < nd; i++)
			chk(rq[8 + i], p[i]);
		rq = {};
		last_at = 0;
		$display("test done at %0t", $time);
	endtask
	task close_out;
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		rst_i = 1;
		rx_valid_i = 0;
		rx_last_i = 0;
		rx_unicast_i = 0;
		rx_data_i = 8'h00;
		fail_next = 0;
		repeat (4) @(negedge clk_i);
		rst_i = 0;
		p = {};
		send(8'h01, 16'h002a, 16'h0005, 16'h0200, 1);
		rep(8'h81, 8'h00, 16'h002a, 16'h0005, 16'h0000, 0);
		p = {8'h5a, 8'ha5};
		send(8'h02, 16'h0016, 16'h01fe, 16'h0002, 1);
		rep(8'h82, 8'h00, 16'h0016, 16'h01fe, 16'h0000, 0);
		chk(i_fdh_flash_model.peek(11774), 8'h5a);
		chk(i_fdh_flash_model.peek(11775), 8'ha5);
		p = {8'h11, 8'h22, 8'h33};
		send(8'h03, 16'h0016, 16'h0000, 16'h0003, 1);
		rep(8'h83, 8'h00, 16'h0016, 16'h0000, 16'h0000, 0);
		chk(i_fdh_flash_model.peek(11774), 8'hff);
		chk(i_fdh_flash_model.peek(11265), 8'h22);
		p = {};
		send(8'h04, 16'h0016, 16'h0000, 16'h0003, 1);
		p = {8'h11, 8'h22, 8'h33};
		rep(8'h84, 8'h00, 16'h0016, 16'h0000, 16'h0003, 3);
		// out of range requests must leave the flash untouched
		n0 = n_ops;
		p = {8'h01};
		send(8'h02, 16'h00a0, 16'h0000, 16'h0001, 1);
		rep(8'h82, 8'h01, 16'h00a0, 16'h0000, 16'h0000, 0);
		p = {8'h01, 8'h02};
		send(8'h02, 16'h0000, 16'h01ff, 16'h0002, 1);
		rep(8'h82, 8'h01, 16'h0000, 16'h01ff, 16'h0000, 0);
		chk(16'(n_ops - n0), 16'h0000);
		p = {8'h77};
		send(8'h02, 16'h0001, 16'h0000, 16'h0001, 0);
		// unknown code: dropped, no reply
		p = {};
		send(8'h07, 16'h0001, 16'h0000, 16'h0000, 1);
		repeat (100) @(posedge clk_i);
		chk(16'(rq.size()), 16'h0000);
		chk(i_fdh_flash_model.peek(512), 8'h77);
		$display("test done at %0t", $time);
		fail_next = 1;
		p = {};
		send(8'h01, 16'h0003, 16'h0000, 16'h0200, 1);
		rep(8'h81, 8'h01, 16'h0003, 16'h0000, 16'h0000, 0);
		fail_next = 0;
		send(8'h03, 16'h0005, 16'h0000, 16'h0000, 1);
		rep(8'h83, 8'h00, 16'h0005, 16'h0000, 16'h0000, 0);
		chk(i_fdh_flash_model.peek(512), 8'hff);
		// stalled sink lets the reply FIFO fill up and refuse
		stall = 1;
		send(8'h04, 16'h0007, 16'h0000, 16'h0018, 1);
		repeat (200) @(posedge clk_i);
		chk(16'(busy_o), 16'h0001);
		stall = 0;
		repeat (24) p.push_back(8'hff);
		rep(8'h84, 8'h00, 16'h0007, 16'h0000, 16'h0018, 24);
		close_out;
	end
	// tests need well under 5000 cycles
	initial
	begin
		#1000000;
		miscompares++;
		close_out;
	end
endmodule
